/* File: plldc_chk.sv */
// concurrent checks on the link and device outputs
`timescale 1ns/1ps
module plldc_chk (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        srst_i,
	// link
	input wire logic        wr_stb,
	input wire logic [7:0]  wr_addr,
	input wire logic [23:0] wr_data,
	input wire logic        rd_req,
	input wire logic        lock_or_readback_pin,
	// device side
	input wire logic        ref_edge_i,
	input wire logic        vco_edge_i,
	input wire logic        phase_err_big_i,
	input wire logic        lock_flag_o,
	input wire logic        frac_mode_o,
	input wire logic [18:0] int_div_o,
	input wire logic [5:0]  out_div_o,
	input wire logic        pd_gain_boost_o
);
	logic [71:0] cfg_q;
	logic [71:0] cfg_p_q;
	logic        settled;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// =========================================================
	// shadow settings; one cycle of agreement marks them settled
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg_q <= '0;
		end else if (wr_stb && wr_addr == plldc_pkg::REG_MODCFG) begin
			cfg_q[23:0] <= wr_data;
		end else if (wr_stb && wr_addr == plldc_pkg::REG_LOCKCFG) begin
			cfg_q[47:24] <= wr_data;
		end else if (wr_stb && wr_addr == plldc_pkg::REG_PINCFG) begin
			cfg_q[71:48] <= wr_data;
		end
	end
	always_ff @(posedge clk_i) begin
		cfg_p_q <= srst_i ? '0 : cfg_q;
	end
	assign settled = (cfg_q == cfg_p_q);
	function automatic logic [5:0] od_fix(input logic [5:0] d);
		return (d <= 6'h01) ? 6'h01 : {d[5:1], 1'b0};
	endfunction : od_fix
	// =========================================================
	// assertions
	// even ratio
	od_range_a: assert property (out_div_o == 6'h01 || !out_div_o[0])
		else $error("odd output divider");
	int_min_a: assert property (int_div_o >= plldc_pkg::INT_MIN_INTEGER)
		else $error("integer divider below floor");
	od_apply_a: assert property (wr_stb && wr_addr == plldc_pkg::REG_OUTDIV
		|-> ##2 out_div_o == od_fix($past(wr_data[5:0], 2))) else $error("divider not applied");
	od_hold_a: assert property ($changed(out_div_o)
		|-> $past(wr_stb && wr_addr == plldc_pkg::REG_OUTDIV, 2)) else $error("divider glitch");
	lock_off_a: assert property (settled && !cfg_q[35] |-> !lock_flag_o)
		else $error("lock while disabled");
	lock_rise_a: assert property ($rose(lock_flag_o) |-> $past(ref_edge_i || vco_edge_i)
		|| $past(ref_edge_i || vco_edge_i, 2)) else $error("lock without edges");
	pin_lock_a: assert property (settled && cfg_q[54] && $stable(lock_flag_o)
		|-> lock_or_readback_pin == lock_flag_o) else $error("pin not lock flag");
	slip_on_a: assert property (settled && cfg_q[0] && phase_err_big_i
		&& $past(phase_err_big_i) |-> pd_gain_boost_o) else $error("no boost");
	slip_off_a: assert property (settled && !cfg_q[0] |-> !pd_gain_boost_o)
		else $error("boost while off");
	frac_mode_a: assert property (settled |-> frac_mode_o == (cfg_q[11] && !cfg_q[7]))
		else $error("wrong divider mode");
	cover property ($rose(lock_flag_o));
	cover property ($fell(lock_flag_o));
	cover property (rd_req);
endmodule : plldc_chk

/* File: plldc_device.sv */
// synthesizer digital control: lock detect, pin mux, divider settings
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module plldc_device (
	// clock and reset (comparison clock)
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// link
	plldc_if.device          lnk,
	// phase detector edge events and large phase error level
	input  wire logic        ref_edge_i,
	input  wire logic        vco_edge_i,
	input  wire logic        phase_err_big_i,
	// lock flag and derived settings
	output logic             lock_flag_o,
	output logic             frac_mode_o,
	output logic [18:0]      int_div_o,
	output logic [23:0]      frac_div_o,
	output logic [13:0]      ref_div_o,
	output logic [5:0]       out_div_o,
	output logic             pd_gain_boost_o
);
	// =========================================================
	// settings registers
	logic [23:0] modcfg_q, lockcfg_q, pincfg_q;
	logic [18:0] int_q;
	logic [23:0] frac_q;
	logic [13:0] ref_q;
	logic [5:0]  outdiv_pend_q;
	logic        outdiv_load_q;
	logic [23:0] shreg_q;
	logic [4:0]  rd_cnt_q;
	logic        rd_busy_q;
	logic        ser_s1_q, ser_s2_q, rdreq_s1_q, rdreq_s2_q, rdreq_s3_q;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			modcfg_q  <= 24'h00_0000;
			lockcfg_q <= 24'h00_0000;
			pincfg_q  <= 24'h00_0000;
			int_q     <= plldc_pkg::INT_MIN_FRAC;
			frac_q    <= 24'h00_0000;
			ref_q     <= plldc_pkg::REFDIV_RST;
		end else if (lnk.wr_stb) begin
			case (lnk.wr_addr)
				plldc_pkg::REG_MODCFG:  modcfg_q  <= lnk.wr_data;
				plldc_pkg::REG_LOCKCFG: lockcfg_q <= lnk.wr_data;
				plldc_pkg::REG_PINCFG:  pincfg_q  <= lnk.wr_data;
				plldc_pkg::REG_INTDIV:  int_q <= (lnk.wr_data[18:0] < plldc_pkg::INT_MIN_INTEGER)
					? plldc_pkg::INT_MIN_INTEGER : lnk.wr_data[18:0];
				plldc_pkg::REG_FRACDIV: frac_q <= lnk.wr_data;
				// reference ratio, zero treated as one
				plldc_pkg::REG_REFDIV:  ref_q <= (lnk.wr_data[13:0] == 14'h0000)
					? plldc_pkg::REFDIV_RST : lnk.wr_data[13:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			outdiv_pend_q <= plldc_pkg::OUTDIV_RST;
			outdiv_load_q <= 1'b0;
			out_div_o     <= plldc_pkg::OUTDIV_RST;
		end else begin
			outdiv_load_q <= lnk.wr_stb && (lnk.wr_addr == plldc_pkg::REG_OUTDIV);
			if (lnk.wr_stb && (lnk.wr_addr == plldc_pkg::REG_OUTDIV)) begin
				// force even ratio, 1 passes through
				outdiv_pend_q <= (lnk.wr_data[5:0] <= 6'h01) ? 6'h01 : {lnk.wr_data[5:1], 1'b0};
			end
			if (outdiv_load_q) begin
				out_div_o <= outdiv_pend_q;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			frac_mode_o     <= 1'b0;
			int_div_o       <= plldc_pkg::INT_MIN_FRAC;
			frac_div_o      <= 24'h00_0000;
			ref_div_o       <= plldc_pkg::REFDIV_RST;
			pd_gain_boost_o <= 1'b0;
		end else begin
			frac_mode_o <= modcfg_q[plldc_pkg::MOD_FRAC_EN_BIT]
				&& !modcfg_q[plldc_pkg::MOD_BYPASS_BIT];
			int_div_o   <= int_q;
			frac_div_o  <= (modcfg_q[plldc_pkg::MOD_FRAC_EN_BIT]) ? frac_q : 24'h00_0000;
			ref_div_o   <= ref_q;
			pd_gain_boost_o <= modcfg_q[plldc_pkg::MOD_SLIP_BIT] && phase_err_big_i;
		end
	end

	// =========================================================
	// lock detector
	function automatic int win_cycles(input logic typ, input logic [1:0] spd,
			input logic [2:0] dv);
		int ps;
		ps = typ ? plldc_pkg::WIN_PS[{spd, dv}] : plldc_pkg::ANALOG_WIN_PS;
		win_cycles = ps / plldc_pkg::CLK_PERIOD_PS;
		if (win_cycles < 1) win_cycles = 1;
	endfunction : win_cycles

	logic [5:0] win_len;
	logic       first_q, ref_seen_q, vco_seen_q, open_q;
	logic [5:0] tmr_q;
	logic [2:0] cnt_q;
	logic       hit, miss;

	assign win_len = 6'(win_cycles(lockcfg_q[plldc_pkg::LK_TYPE_BIT],
		lockcfg_q[plldc_pkg::LK_SPEED_LSB +: 2], lockcfg_q[plldc_pkg::LK_DIV_LSB +: 3]));
	assign hit  = open_q && (ref_edge_i || ref_seen_q) && (vco_edge_i || vco_seen_q);
	assign miss = open_q && !hit && (tmr_q >= win_len);

	always_ff @(posedge clk_i) begin
		if (srst_i || !lockcfg_q[plldc_pkg::LK_EN_BIT]) begin
			open_q      <= 1'b0;
			ref_seen_q  <= 1'b0;
			vco_seen_q  <= 1'b0;
			tmr_q       <= 6'h00;
			cnt_q       <= 3'h0;
			lock_flag_o <= 1'b0;
		end else if (!open_q) begin
			open_q     <= ref_edge_i || vco_edge_i;
			ref_seen_q <= ref_edge_i;
			vco_seen_q <= vco_edge_i;
			tmr_q      <= 6'h01;
			if (ref_edge_i && vco_edge_i) begin
				open_q <= 1'b0;
				if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
				if (cnt_q + 3'h1 >= lockcfg_q[plldc_pkg::LK_THR_LSB +: 3]) lock_flag_o <= 1'b1;
			end
		end else if (hit) begin
			open_q <= 1'b0;
			if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
			if (cnt_q + 3'h1 >= lockcfg_q[plldc_pkg::LK_THR_LSB +: 3]) lock_flag_o <= 1'b1;
		end else if (miss) begin
			open_q <= 1'b0;
			cnt_q <= 3'h0;
			lock_flag_o <= 1'b0;
		end else begin
			ref_seen_q <= ref_seen_q || ref_edge_i;
			vco_seen_q <= vco_seen_q || vco_edge_i;
			tmr_q <= tmr_q + 6'h01;
		end
	end

	// =========================================================
	// serial readback: synchronise host pins
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ser_s1_q   <= 1'b0;
			ser_s2_q   <= 1'b0;
			rdreq_s1_q <= 1'b0;
			rdreq_s2_q <= 1'b0;
			rdreq_s3_q <= 1'b0;
		end else begin
			ser_s1_q   <= lnk.ser_in;
			ser_s2_q   <= ser_s1_q;
			rdreq_s1_q <= lnk.rd_req;
			rdreq_s2_q <= rdreq_s1_q;
			rdreq_s3_q <= rdreq_s2_q;
		end
	end

	function automatic logic [23:0] read_reg(input logic [7:0] a, input logic lk);
		case (a)
			plldc_pkg::REG_REFDIV:  read_reg = {10'h000, ref_q};
			plldc_pkg::REG_INTDIV:  read_reg = {5'h00, int_q};
			plldc_pkg::REG_FRACDIV: read_reg = frac_q;
			plldc_pkg::REG_MODCFG:  read_reg = modcfg_q;
			plldc_pkg::REG_LOCKCFG: read_reg = lockcfg_q;
			plldc_pkg::REG_PINCFG:  read_reg = pincfg_q;
			plldc_pkg::REG_OUTDIV:  read_reg = {18'h0_0000, out_div_o};
			plldc_pkg::REG_STATUS:  read_reg = 24'(lk) << plldc_pkg::STAT_LOCK_BIT;
			default:                read_reg = 24'h00_0000;
		endcase
	endfunction : read_reg

	// address shifts in while rd_req high, data shifts out after it falls unless the pin-only bit is set
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			shreg_q   <= 24'h00_0000;
			rd_cnt_q  <= 5'h00;
			rd_busy_q <= 1'b0;
		end else if (rdreq_s2_q) begin
			shreg_q <= {shreg_q[22:0], ser_s2_q};
			rd_busy_q <= 1'b0;
		end else if (rdreq_s3_q) begin
			shreg_q  <= read_reg(shreg_q[7:0], lock_flag_o);
			rd_cnt_q <= 5'(plldc_pkg::SER_DATA_BITS);
			rd_busy_q <= !pincfg_q[plldc_pkg::PIN_ONLY_BIT];
		end else if (rd_busy_q) begin
			shreg_q  <= {shreg_q[22:0], 1'b0};
			rd_cnt_q <= rd_cnt_q - 5'h01;
			rd_busy_q <= (rd_cnt_q != 5'h01);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) lnk.lock_or_readback_pin <= 1'b0;
		else if (rd_busy_q) lnk.lock_or_readback_pin <= shreg_q[23];
		else if (pincfg_q[4:0] == plldc_pkg::PIN_SEL_LOCK || pincfg_q[plldc_pkg::PIN_ONLY_BIT])
			lnk.lock_or_readback_pin <= lock_flag_o;
		else lnk.lock_or_readback_pin <= 1'b0;
	end
endmodule : plldc_device

/* File: plldc_host.sv */
// host side: configures the synthesizer and reads lock and readback
`timescale 1ns/1ps
module plldc_host (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// software port
	input  wire logic [7:0]  addr_i,
	input  wire logic [23:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [23:0]      rdata_o,
	output logic             rd_done_o,
	output logic             lock_o,
	// link
	plldc_if.host            lnk
);
	plldc_pkg::plldc_hstate_e st_q;
	logic [7:0]  addr_q;
	logic [5:0]  cnt_q;
	logic [23:0] data_q;
	logic        pin_s1_q, pin_s2_q;

	// software writes pass straight to the device
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lnk.wr_stb  <= 1'b0;
			lnk.wr_addr <= 8'h00;
			lnk.wr_data <= 24'h00_0000;
		end else begin
			lnk.wr_stb  <= wr_i;
			lnk.wr_addr <= addr_i;
			lnk.wr_data <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= lnk.lock_or_readback_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	// request spans one cycle more than the address bits so the device keeps the last eight
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q       <= plldc_pkg::PLLDC_H_IDLE;
			addr_q     <= 8'h00;
			cnt_q      <= 6'h00;
			data_q     <= 24'h00_0000;
			rdata_o    <= 24'h00_0000;
			rd_done_o  <= 1'b0;
			lnk.rd_req <= 1'b0;
			lnk.ser_in <= 1'b0;
			lock_o     <= 1'b0;
		end else begin
			rd_done_o <= 1'b0;
			case (st_q)
				plldc_pkg::PLLDC_H_IDLE: begin
					lock_o <= pin_s2_q;
					if (rd_i) begin
						addr_q     <= addr_i;
						cnt_q      <= 6'h00;
						lnk.rd_req <= 1'b1;
						st_q <= plldc_pkg::PLLDC_H_ADDR;
					end
				end
				plldc_pkg::PLLDC_H_ADDR: begin
					lnk.ser_in <= addr_q[7];
					addr_q <= {addr_q[6:0], 1'b0};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == 6'(plldc_pkg::SER_ADDR_BITS)) begin
						lnk.rd_req <= 1'b0;
						cnt_q      <= 6'h00;
						st_q <= plldc_pkg::PLLDC_H_DATA;
					end
				end
				plldc_pkg::PLLDC_H_DATA: begin
					cnt_q <= cnt_q + 6'h01;
					// first data bit reaches pin_s2_q six cycles into this state
					if (cnt_q >= 6'h06) data_q <= {data_q[22:0], pin_s2_q};
					if (cnt_q == 6'(plldc_pkg::SER_DATA_BITS + 5)) begin
						rdata_o   <= {data_q[22:0], pin_s2_q};
						rd_done_o <= 1'b1;
						st_q <= plldc_pkg::PLLDC_H_IDLE;
					end
				end
				default: st_q <= plldc_pkg::PLLDC_H_IDLE;
			endcase
		end
	end
endmodule : plldc_host

/* File: plldc_if.sv */
// link between the synthesizer control device and its host
`timescale 1ns/1ps
interface plldc_if;
	logic        wr_stb;
	logic [7:0]  wr_addr;
	logic [23:0] wr_data;
	logic        rd_req;
	logic        ser_in;
	logic        lock_or_readback_pin;
	modport device (
		input  wr_stb, wr_addr, wr_data, rd_req, ser_in,
		output lock_or_readback_pin
	);
	modport host (
		output wr_stb, wr_addr, wr_data, rd_req, ser_in,
		input  lock_or_readback_pin
	);
endinterface : plldc_if

/* File: plldc_pkg.sv */
// package of constants shared by the synthesizer control device and its host
package plldc_pkg;
	// =========================================================
	// device register indices (printed offsets)
	localparam logic [7:0] REG_REFDIV   = 8'h02;
	localparam logic [7:0] REG_INTDIV   = 8'h03;
	localparam logic [7:0] REG_FRACDIV  = 8'h04;
	localparam logic [7:0] REG_MODCFG   = 8'h06;
	localparam logic [7:0] REG_LOCKCFG  = 8'h07;
	localparam logic [7:0] REG_CPCFG    = 8'h09;
	localparam logic [7:0] REG_PINCFG   = 8'h0F;
	localparam logic [7:0] REG_STATUS   = 8'h12;
	localparam logic [7:0] REG_OUTDIV   = 8'h16;
	// =========================================================
	// field positions
	localparam int MOD_FRAC_EN_BIT  = 11;
	localparam int MOD_BYPASS_BIT   = 7;
	localparam int MOD_SLIP_BIT     = 0;
	localparam int LK_EN_BIT        = 11;
	localparam int LK_SPEED_LSB     = 8;
	localparam int LK_DIV_LSB       = 5;
	localparam int LK_TYPE_BIT      = 6;
	localparam int LK_THR_LSB       = 0;
	localparam int PIN_ONLY_BIT     = 6;
	localparam int STAT_LOCK_BIT    = 1;
	localparam logic [4:0] PIN_SEL_LOCK = 5'h01;
	// =========================================================
	// limits and reset values
	localparam logic [18:0] INT_MIN_INTEGER = 19'h0_0010;
	localparam logic [18:0] INT_MIN_FRAC    = 19'h0_0014;
	localparam logic [18:0] INT_MAX_FRAC    = 19'h7_FFFC;
	localparam logic [13:0] REFDIV_RST      = 14'h0001;
	localparam logic [5:0]  OUTDIV_RST      = 6'h01;
	// =========================================================
	// timing: clock 100 MHz, windows in picoseconds
	localparam int CLK_PERIOD_PS  = 10000;
	localparam int ANALOG_WIN_PS  = 10000;
	localparam int ANALOG_WIN_CYC = ANALOG_WIN_PS / CLK_PERIOD_PS;
	// window length per speed and divide code, ps (speed*8+div)
	localparam int WIN_PS [32] = '{
		6500, 8000, 11000, 17000, 29000, 53000, 100000, 195000,
		7000, 8900, 12800, 21000, 36000, 68000, 130000, 255000,
		7100, 9200, 13300, 22000, 38000, 72000, 138000, 272000,
		7600, 10200, 15400, 26000, 47000, 88000, 172000, 338000};
	// serial frame: 8 address bits out, 24 data bits back
	localparam int SER_ADDR_BITS = 8;
	localparam int SER_DATA_BITS = 24;
	typedef enum logic [2:0] {
		PLLDC_H_IDLE = 3'b001,
		PLLDC_H_ADDR = 3'b010,
		PLLDC_H_DATA = 3'b100
	} plldc_hstate_e;
endpackage : plldc_pkg

/* File: tb_pll_lock_detect_and_divider_control.sv */
// self-checking bench joining host and device
`timescale 1ns/1ps
module tb_pll_lock_detect_and_divider_control;
	// =========================================================
	// stimulus and observed outputs
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [23:0] wdata = 24'h00_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ref_edge = 1'b0;
	logic        vco_edge = 1'b0;
	logic        perr = 1'b0;
	logic [23:0] rdata, frac_div, rval;
	logic        rd_done, lock, lock_flag, frac_mode, boost;
	logic [18:0] int_div;
	logic [13:0] ref_div;
	logic [5:0]  out_div;
	int          num_errors = 0;
	int          cmp_count = 0;
	logic [5:0]  od_in [6] = '{6'h00, 6'h01, 6'h02, 6'h07, 6'h3E, 6'h3F};
	logic [5:0]  od_ex [6] = '{6'h01, 6'h01, 6'h02, 6'h06, 6'h3E, 6'h3E};
	always #5 clk_i = ~clk_i;
	plldc_if plldc_if_i ();
	plldc_device plldc_device_i (.clk_i(clk_i), .srst_i(srst_i), .lnk(plldc_if_i.device),
		.ref_edge_i(ref_edge), .vco_edge_i(vco_edge), .phase_err_big_i(perr),
		.lock_flag_o(lock_flag), .frac_mode_o(frac_mode), .int_div_o(int_div),
		.frac_div_o(frac_div), .ref_div_o(ref_div), .out_div_o(out_div), .pd_gain_boost_o(boost));
	plldc_host plldc_host_i (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rd_done_o(rd_done), .lock_o(lock),
		.lnk(plldc_if_i.host));
	plldc_chk plldc_chk_i (.clk_i(clk_i), .srst_i(srst_i), .wr_stb(plldc_if_i.wr_stb),
		.wr_addr(plldc_if_i.wr_addr), .wr_data(plldc_if_i.wr_data), .rd_req(plldc_if_i.rd_req),
		.lock_or_readback_pin(plldc_if_i.lock_or_readback_pin), .ref_edge_i(ref_edge),
		.vco_edge_i(vco_edge), .phase_err_big_i(perr), .lock_flag_o(lock_flag),
		.frac_mode_o(frac_mode), .int_div_o(int_div), .out_div_o(out_div),
		.pd_gain_boost_o(boost));
	// =========================================================
	// tasks
	task automatic close_out();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [23:0] d);
		int n;
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		for (n = 0; n < 200; n++) begin
			@(posedge clk_i);
			if (rd_done === 1'b1) break;
		end
		if (n == 200) begin
			num_errors++;
			close_out();
		end
		d = rdata;
		repeat (2) @(posedge clk_i);
	endtask : rd_reg
	// gap 0: edges together; gap below 0: reference edge alone
	task automatic edges(input int gap);
		@(posedge clk_i);
		ref_edge <= 1'b1;
		vco_edge <= (gap == 0);
		@(posedge clk_i);
		ref_edge <= 1'b0;
		vco_edge <= 1'b0;
		if (gap > 0) begin
			repeat (gap - 1) @(posedge clk_i);
			vco_edge <= 1'b1;
			@(posedge clk_i);
			vco_edge <= 1'b0;
		end
		repeat (15) @(posedge clk_i);
	endtask : edges
	task automatic lock_up(input int gap);
		for (int k = 0; k < 3; k++) begin
			edges(gap);
			chk(24'(lock_flag), 24'(k == 2));
		end
	endtask : lock_up
	// =========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk(24'(int_div), 24'h00_0014);
		chk(24'(out_div), 24'h00_0001);
		chk(24'(lock_flag), 24'h00_0000);
		for (int i = 0; i < 6; i++) begin
			wr_reg(plldc_pkg::REG_OUTDIV, {18'h0_0000, od_in[i]});
			chk(24'(out_div), 24'(od_ex[i]));
		end
		wr_reg(plldc_pkg::REG_REFDIV, 24'h00_0000);
		chk(24'(ref_div), 24'h00_0001);
		wr_reg(plldc_pkg::REG_REFDIV, 24'h00_0005);
		chk(24'(ref_div), 24'h00_0005);
		wr_reg(plldc_pkg::REG_MODCFG, 24'h00_0080);
		wr_reg(plldc_pkg::REG_CPCFG, 24'h00_0000);
		wr_reg(plldc_pkg::REG_INTDIV, 24'h00_0005);
		chk(24'(int_div), 24'h00_0010);
		wr_reg(plldc_pkg::REG_INTDIV, 24'h07_FFFF);
		chk(24'(int_div), 24'h07_FFFF);
		perr <= 1'b1;
		wr_reg(plldc_pkg::REG_MODCFG, 24'h00_0081);
		chk(24'(boost), 24'h00_0001);
		wr_reg(plldc_pkg::REG_MODCFG, 24'h00_0080);
		chk(24'(boost), 24'h00_0000);
		chk(24'(frac_mode), 24'h00_0000);
		perr <= 1'b0;
		// fractional mode, integer part in range
		wr_reg(plldc_pkg::REG_MODCFG, 24'h00_0800);
		wr_reg(plldc_pkg::REG_FRACDIV, 24'h19_999A);
		wr_reg(plldc_pkg::REG_INTDIV, 24'h00_0038);
		chk(24'(frac_mode), 24'h00_0001);
		chk(frac_div, 24'h19_999A);
		chk(24'(int_div), 24'h00_0038);
		wr_reg(plldc_pkg::REG_PINCFG, 24'h00_0001);
		wr_reg(plldc_pkg::REG_LOCKCFG, 24'h00_0803);
		lock_up(0);
		chk(24'(lock), 24'h00_0001);
		rd_reg(plldc_pkg::REG_STATUS, rval);
		chk(rval, 24'h00_0002);
		edges(-1);
		chk(24'(lock_flag), 24'h00_0000);
		chk(24'(lock), 24'h00_0000);
		// digital window of ten cycles admits a five-cycle gap
		wr_reg(plldc_pkg::REG_LOCKCFG, 24'h00_08C3);
		lock_up(5);
		wr_reg(plldc_pkg::REG_LOCKCFG, 24'h00_0803);
		edges(5);
		chk(24'(lock_flag), 24'h00_0000);
		wr_reg(plldc_pkg::REG_LOCKCFG, 24'h00_08C3);
		lock_up(5);
		wr_reg(plldc_pkg::REG_PINCFG, 24'h00_0041);
		rd_reg(plldc_pkg::REG_STATUS, rval);
		chk(rval, 24'hFF_FFFF);
		wr_reg(plldc_pkg::REG_LOCKCFG, 24'h00_00C3);
		chk(24'(lock_flag), 24'h00_0000);
		close_out();
	end
endmodule : tb_pll_lock_detect_and_divider_control
